// File: include/fsq_pkg.sv
// constants shared by the flash sequencer modules
// Functional notes
// R01 - processor cache hit answers in one cycle
// R02 - flash cache hit answers in three cycles
// R03 - full miss: three or four by wait select
// R04 - commands decoded at the fixed command window
// R05 - serial programmer path also issues commands
// R06 - data flash readable during code flash work
// R07 - code flash readable during data flash work
// R08 - programming always takes a full 128-byte unit; option programming streams only 4 words
// R09 - erase only whole blocks
// R10 - interrupt fetches keep flowing during self-programming
// R11 - protection enable blocks unintended program or erase
// R12 - user area limited to 512 KB
// R13 - option expansion area chosen at initial settings
// R14 - busy flag, same-area commands held off
// R15 - erased block reads back all ones
package fsq_pkg;
  localparam logic [31:0] CMD_WINDOW = 32'h407e_0000;
  localparam logic [1:0] OP_PROG = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h2;
  localparam logic [1:0] OP_OPT = 2'h3;
  localparam logic [1:0] AREA_CODE = 2'h0;
  localparam logic [1:0] AREA_DATA = 2'h1;
  localparam logic [1:0] AREA_OPT = 2'h2;
  localparam int OPC_POS = 0;
  localparam int ADDR_POS = 0;
  localparam int AREA_POS = 24;
  localparam logic [4:0] PROG_LAST = 5'h1f;
  localparam logic [4:0] OPT_LAST = 5'h03;
  localparam logic [19:0] OPT_BASE_LIMIT = 20'h00010;
  localparam int CF_BLK_BITS = 15;
  localparam int DF_BLK_BITS = 13;
  localparam int DF_ADDR_BITS = 16;
  localparam int UNIT_BITS = 7;
  localparam logic [7:0] WAIT_SEL_FAST = 8'h00;
  localparam logic [7:0] WAIT_SEL_SLOW = 8'h01;
  localparam logic [2:0] LAT_CPU_HIT = 3'h1;
  localparam logic [2:0] LAT_FLASH_HIT = 3'h3;
  localparam logic [2:0] LAT_MISS_FAST = 3'h3;
  localparam logic [2:0] LAT_MISS_SLOW = 3'h4;
  localparam logic [31:0] ERASED_WORD = 32'hffff_ffff;
endpackage

// File: include/fsq_cmd_if.sv
// command hand-off between a command parser and the sequencer
`timescale 1ns/10ps
interface fsq_cmd_if;
  logic valid;
  logic [1:0] op;
  logic [1:0] area;
  logic [19:0] addr;
  logic [31:0] word;
  logic err;
  logic take;
  logic [4:0] idx;
  modport prs (output valid, op, area, addr, word, err, input take, idx);
  modport ctl (input valid, op, area, addr, word, err, output take, idx);
endinterface

// File: src/fsq_cmd_parse.sv
// command window parser: opcode, target, then the data unit
`timescale 1ns/10ps
module fsq_cmd_parse (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr,
  input wire logic [31:0] wdata,
  output logic ready,
  fsq_cmd_if.prs cmd
);
  typedef enum logic [3:0] {
    P_OPC = 4'b0001,
    P_ADR = 4'b0010,
    P_DAT = 4'b0100,
    P_HOLD = 4'b1000
  } fsq_pst_t;

  fsq_pst_t st_r;
  logic [1:0] op_r;
  logic [1:0] area_r;
  logic [19:0] addr_r;
  logic [4:0] cnt_r;
  logic err_r;
  logic [31:0] unit_mem [0:31];

  wire [7:0] opc = wdata[fsq_pkg::OPC_POS +: 8];
  wire opc_ok = (opc[7:2] == 6'h00) && (opc[1:0] != 2'h0);
  wire [4:0] last = (op_r == fsq_pkg::OP_OPT) ? fsq_pkg::OPT_LAST : fsq_pkg::PROG_LAST;
  wire acc = wr && ready;

  assign ready = (st_r != P_HOLD);
  assign cmd.valid = (st_r == P_HOLD);
  assign cmd.op = op_r;
  assign cmd.area = area_r;
  assign cmd.addr = addr_r;
  assign cmd.err = err_r;
  assign cmd.word = unit_mem[cmd.idx];

  always_ff @(posedge clk)
  begin
    if (acc && st_r == P_DAT)
      unit_mem[cnt_r] <= wdata;
  end

  always_ff @(posedge clk)
  begin
    err_r <= 1'b0;
    if (rst)
    begin
      st_r <= P_OPC;
      op_r <= 2'h0;
      area_r <= 2'h0;
      addr_r <= 20'h00000;
      cnt_r <= 5'h00;
    end
    else
    begin
      case (st_r)
        P_OPC:
          if (acc)
          begin
            op_r <= opc[1:0];
            st_r <= opc_ok ? P_ADR : P_OPC;
            err_r <= !opc_ok;
          end
        P_ADR:
          if (acc)
          begin
            addr_r <= wdata[fsq_pkg::ADDR_POS +: 20];
            area_r <= (op_r == fsq_pkg::OP_OPT) ? fsq_pkg::AREA_OPT : wdata[fsq_pkg::AREA_POS +: 2];
            cnt_r <= 5'h00;
            st_r <= (op_r == fsq_pkg::OP_ERASE) ? P_HOLD : P_DAT;
          end
        P_DAT:
          if (acc)
          begin
            // the unit is complete only after the last word
            cnt_r <= cnt_r + 5'h01; // R08
            if (cnt_r == last)
              st_r <= P_HOLD; // R08
          end
        P_HOLD:
          if (cmd.take)
            st_r <= P_OPC;
        default:
          st_r <= P_OPC;
      endcase
    end
  end
endmodule

// File: src/fsq_flash_ctrl.sv
// flash read timing and program/erase sequencer
`timescale 1ns/10ps
module fsq_flash_ctrl (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic RD_REQ,
  input wire logic RD_AREA,
  input wire logic [18:0] RD_ADDR,
  input wire logic RD_CPU_HIT,
  input wire logic RD_FLASH_HIT,
  input wire logic [7:0] FLASH_READ_WAIT_SELECT,
  output logic RD_READY,
  output logic RD_VALID,
  output logic [31:0] RD_DATA,
  input wire logic CMD_WR,
  input wire logic [31:0] CMD_ADDR,
  input wire logic [31:0] CMD_WDATA,
  output logic CMD_READY,
  input wire logic SER_WR,
  input wire logic [31:0] SER_WDATA,
  output logic SER_READY,
  input wire logic PE_ENABLE,
  input wire logic OPT_EXPAND,
  output logic ARR_RD_AREA,
  output logic [18:0] ARR_RD_ADDR,
  input wire logic [31:0] ARR_RD_DATA,
  output logic ARR_CMD_STB,
  output logic [1:0] ARR_CMD_OP,
  output logic [1:0] ARR_CMD_AREA,
  output logic [18:0] ARR_CMD_ADDR,
  output logic ARR_WR_STB,
  output logic [31:0] ARR_WR_DATA,
  input wire logic [1:0] ARR_DONE,
  output logic [1:0] BUSY,
  output logic CMD_ERR
);
  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_STREAM = 2'b10
  } fsq_st_t;

  fsq_cmd_if self_if ();
  fsq_cmd_if ser_if ();

  // self-programming path: only writes that land on the window count
  wire win_hit = (CMD_ADDR == fsq_pkg::CMD_WINDOW); // R04
  wire self_ready;

  fsq_cmd_parse u_self (
    .clk(SYS_CLK),
    .rst(SRST),
    .wr(CMD_WR && win_hit), // R04
    .wdata(CMD_WDATA),
    .ready(self_ready),
    .cmd(self_if.prs)
  );

  fsq_cmd_parse u_ser (
    .clk(SYS_CLK),
    .rst(SRST),
    .wr(SER_WR), // R05
    .wdata(SER_WDATA),
    .ready(SER_READY),
    .cmd(ser_if.prs)
  );

  // window writes elsewhere are not ours and are never stalled
  assign CMD_READY = self_ready || !win_hit;

  fsq_st_t st_r;
  fsq_st_t st_nxt;
  logic [1:0] busy_r;
  logic [4:0] idx_r;
  logic [4:0] idx_nxt;
  logic use_ser_r;
  logic opt_exp_r;
  logic cap_done_r;
  logic [15:0] cf_erased_r;
  logic [7:0] df_erased_r;
  logic rd_act_r;
  logic [2:0] rd_cnt_r;
  logic rd_valid_r;
  logic [31:0] rd_data_r;
  logic rd_area_r;
  logic [18:0] rd_addr_r;
  logic cmd_stb_r;
  logic [1:0] cmd_op_r;
  logic [1:0] cmd_area_r;
  logic [18:0] cmd_addr_r;
  logic wr_stb_r;
  logic [31:0] wr_data_r;
  logic err_r;

  // selection between the two command sources; self-programming first
  wire sel_ser = !self_if.valid && ser_if.valid;
  wire c_valid = self_if.valid || ser_if.valid;
  wire [1:0] c_op = sel_ser ? ser_if.op : self_if.op;
  wire [1:0] c_area = sel_ser ? ser_if.area : self_if.area;
  wire [19:0] c_addr = sel_ser ? ser_if.addr : self_if.addr;
  wire [31:0] s_word = use_ser_r ? ser_if.word : self_if.word;
  wire [1:0] s_op = use_ser_r ? ser_if.op : self_if.op;

  // option memory sits in the code bank
  wire c_bank = (c_area == fsq_pkg::AREA_DATA);
  wire bank_busy = busy_r[c_bank]; // R14
  wire area_bad = (c_area == 2'h3) || ((c_area == fsq_pkg::AREA_OPT) != (c_op == fsq_pkg::OP_OPT));
  wire range_bad = c_addr[19] || // R12
    ((c_area == fsq_pkg::AREA_DATA) && (c_addr[18:fsq_pkg::DF_ADDR_BITS] != 3'h0));
  wire opt_bad = (c_op == fsq_pkg::OP_OPT) && (c_addr >= fsq_pkg::OPT_BASE_LIMIT) && !opt_exp_r; // R13
  wire refuse = !PE_ENABLE || area_bad || range_bad || opt_bad; // R11
  wire launch = (st_r == S_IDLE) && c_valid && !bank_busy; // R14
  wire go = launch && !refuse;
  wire is_prog = (c_op != fsq_pkg::OP_ERASE);

  // erase is forced to the enclosing block, programming to its unit
  wire [18:0] cf_blk = {c_addr[18:fsq_pkg::CF_BLK_BITS], {fsq_pkg::CF_BLK_BITS{1'b0}}}; // R09
  wire [18:0] df_blk = {c_addr[18:fsq_pkg::DF_BLK_BITS], {fsq_pkg::DF_BLK_BITS{1'b0}}}; // R09
  wire [18:0] unit_a = {c_addr[18:fsq_pkg::UNIT_BITS], {fsq_pkg::UNIT_BITS{1'b0}}}; // R08
  wire [18:0] launch_a = is_prog ? unit_a : (c_bank ? df_blk : cf_blk);
  wire [3:0] cf_bi = c_addr[18:fsq_pkg::CF_BLK_BITS];
  wire [2:0] df_bi = c_addr[fsq_pkg::DF_ADDR_BITS - 1:fsq_pkg::DF_BLK_BITS];
  wire upd_code = go && (c_area == fsq_pkg::AREA_CODE);
  wire upd_data = go && (c_area == fsq_pkg::AREA_DATA);

  wire [4:0] s_last = (s_op == fsq_pkg::OP_OPT) ? fsq_pkg::OPT_LAST : fsq_pkg::PROG_LAST;
  wire s_end = (st_r == S_STREAM) && (idx_r == s_last);
  wire take = (launch && (refuse || !is_prog)) || s_end;

  assign self_if.take = take && !(launch ? sel_ser : use_ser_r);
  assign ser_if.take = take && (launch ? sel_ser : use_ser_r);
  assign self_if.idx = idx_r;
  assign ser_if.idx = idx_r;

  always_comb
  begin
    st_nxt = st_r;
    idx_nxt = idx_r;
    case (st_r)
      S_IDLE:
        if (go && is_prog)
        begin
          st_nxt = S_STREAM;
          idx_nxt = 5'h00;
        end
      S_STREAM:
        begin
          idx_nxt = idx_r + 5'h01;
          if (s_end)
            st_nxt = S_IDLE;
        end
      default:
        st_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      st_r <= S_IDLE;
      idx_r <= 5'h00;
      use_ser_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      idx_r <= idx_nxt;
      if (launch)
        use_ser_r <= sel_ser;
    end
  end

  // expansion choice is caught once, right after reset is released
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      cap_done_r <= 1'b0;
      opt_exp_r <= 1'b0;
    end
    else if (!cap_done_r)
    begin
      cap_done_r <= 1'b1;
      opt_exp_r <= OPT_EXPAND; // R13
    end
  end

  // busy sets only on an idle bank, so set and done never collide
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      busy_r <= 2'b00;
    else
      busy_r <= (busy_r & ~ARR_DONE) | ({1'b0, go} << c_bank); // R14
  end

  // erased-block map; unknown contents after reset read from the array
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      cf_erased_r <= 16'h0000;
      df_erased_r <= 8'h00;
    end
    else
    begin
      if (upd_code)
        cf_erased_r[cf_bi] <= !is_prog; // R15
      if (upd_data)
        df_erased_r[df_bi] <= !is_prog; // R15
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      cmd_stb_r <= 1'b0;
      cmd_op_r <= 2'h0;
      cmd_area_r <= 2'h0;
      cmd_addr_r <= 19'h00000;
      wr_stb_r <= 1'b0;
      wr_data_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end
    else
    begin
      cmd_stb_r <= go;
      if (go)
      begin
        cmd_op_r <= c_op;
        cmd_area_r <= c_area;
        cmd_addr_r <= launch_a;
      end
      wr_stb_r <= (st_r == S_STREAM); // R08
      wr_data_r <= s_word;
      err_r <= (launch && refuse) || self_if.err || ser_if.err; // R11
    end
  end

  // read latency by cache outcome and wait select
  wire [2:0] miss_lat = (FLASH_READ_WAIT_SELECT == fsq_pkg::WAIT_SEL_FAST) ?
    fsq_pkg::LAT_MISS_FAST : fsq_pkg::LAT_MISS_SLOW; // R03
  wire [2:0] rd_lat = RD_CPU_HIT ? fsq_pkg::LAT_CPU_HIT : // R01
    (RD_FLASH_HIT ? fsq_pkg::LAT_FLASH_HIT : miss_lat); // R02
  // only the bank being worked on stalls; vector fetches from the other keep going
  assign RD_READY = !rd_act_r && !busy_r[RD_AREA]; // R06 R07 R10
  wire rd_take = RD_REQ && RD_READY;
  wire rd_erased = rd_area_r ? df_erased_r[rd_addr_r[fsq_pkg::DF_ADDR_BITS - 1:fsq_pkg::DF_BLK_BITS]] :
    cf_erased_r[rd_addr_r[18:fsq_pkg::CF_BLK_BITS]];

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      rd_act_r <= 1'b0;
      rd_cnt_r <= 3'h0;
      rd_valid_r <= 1'b0;
      rd_data_r <= 32'h0000_0000;
      rd_area_r <= 1'b0;
      rd_addr_r <= 19'h00000;
    end
    else
    begin
      rd_valid_r <= 1'b0;
      if (rd_take)
      begin
        rd_act_r <= 1'b1;
        rd_cnt_r <= rd_lat - 3'h1; // R01 R02 R03
        rd_area_r <= RD_AREA;
        rd_addr_r <= RD_ADDR;
      end
      else if (rd_act_r)
      begin
        if (rd_cnt_r == 3'h0)
        begin
          rd_act_r <= 1'b0;
          rd_valid_r <= 1'b1;
          rd_data_r <= rd_erased ? fsq_pkg::ERASED_WORD : ARR_RD_DATA; // R15
        end
        else
          rd_cnt_r <= rd_cnt_r - 3'h1;
      end
    end
  end

  assign RD_VALID = rd_valid_r;
  assign RD_DATA = rd_data_r;
  assign ARR_RD_AREA = rd_area_r;
  assign ARR_RD_ADDR = rd_addr_r;
  assign ARR_CMD_STB = cmd_stb_r;
  assign ARR_CMD_OP = cmd_op_r;
  assign ARR_CMD_AREA = cmd_area_r;
  assign ARR_CMD_ADDR = cmd_addr_r;
  assign ARR_WR_STB = wr_stb_r;
  assign ARR_WR_DATA = wr_data_r;
  assign BUSY = busy_r;
  assign CMD_ERR = err_r;
endmodule

// File: sim/fsq_ctrl_monitor.sv
// port checker for the flash sequencer
`timescale 1ns/10ps
module fsq_ctrl_chk (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic RD_REQ,
  input wire logic RD_AREA,
  input wire logic RD_CPU_HIT,
  input wire logic RD_FLASH_HIT,
  input wire logic [7:0] FLASH_READ_WAIT_SELECT,
  input wire logic RD_READY,
  input wire logic RD_VALID,
  input wire logic ARR_CMD_STB,
  input wire logic [1:0] ARR_CMD_OP,
  input wire logic [1:0] ARR_CMD_AREA,
  input wire logic [18:0] ARR_CMD_ADDR,
  input wire logic ARR_WR_STB,
  input wire logic [1:0] ARR_DONE,
  input wire logic [1:0] BUSY
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  logic [5:0] run_r;
  wire take = RD_REQ && RD_READY;
  wire miss = take && !RD_CPU_HIT && !RD_FLASH_HIT;
  wire bank = ARR_CMD_AREA == 2'h1;
  wire era = ARR_CMD_STB && ARR_CMD_OP == 2'h2;
  // run length of the write strobe, judged when it drops
  always_ff @(posedge SYS_CLK)
    run_r <= (SRST || !ARR_WR_STB) ? 6'h00 : run_r + 6'h01;
  // the answer flop rises on the edge take+L, so it is first sampled high one edge later
  sequence s_wait3;
    !RD_VALID [*3];
  endsequence
  a_cpu_hit: assert property (take && RD_CPU_HIT |=> !RD_VALID ##1 RD_VALID)
    else $error("cpu hit latency wrong");
  a_flash_hit: assert property (take && !RD_CPU_HIT && RD_FLASH_HIT |=> s_wait3 ##1 RD_VALID)
    else $error("flash hit latency wrong");
  a_miss_fast: assert property (miss && FLASH_READ_WAIT_SELECT == 8'h00 |=> s_wait3 ##1 RD_VALID)
    else $error("fast miss latency wrong");
  a_miss_slow: assert property (miss && FLASH_READ_WAIT_SELECT != 8'h00 |=> s_wait3 ##1 !RD_VALID ##1 RD_VALID)
    else $error("slow miss latency wrong");
  a_busy_hold: assert property (BUSY[RD_AREA] |-> !RD_READY)
    else $error("read taken on busy bank");
  a_launch_idle: assert property (ARR_CMD_STB |-> BUSY[bank] && ($past(BUSY) & (bank ? 2'h2 : 2'h1)) == 2'h0)
    else $error("launch on busy bank");
  a_busy_clear: assert property ((ARR_DONE & BUSY) != 2'h0 |=> (BUSY & $past(ARR_DONE)) == 2'h0)
    else $error("busy not cleared after done");
  a_unit_len: assert property ($fell(ARR_WR_STB) |-> run_r == 6'h20 || run_r == 6'h04)
    else $error("write stream length wrong");
  a_stream_go: assert property (ARR_CMD_STB && !era |-> !ARR_WR_STB ##1 ARR_WR_STB)
    else $error("stream not started with command");
  a_block_align: assert property (era |-> !ARR_WR_STB && ARR_CMD_ADDR[12:0] == 13'h0000 && (bank || ARR_CMD_ADDR[14:13] == 2'h0))
    else $error("erase not whole block");
endmodule
bind fsq_flash_ctrl fsq_ctrl_chk i_fsq_ctrl_chk (.SYS_CLK, .SRST, .RD_REQ, .RD_AREA, .RD_CPU_HIT, .RD_FLASH_HIT,
  .FLASH_READ_WAIT_SELECT, .RD_READY, .RD_VALID, .ARR_CMD_STB, .ARR_CMD_OP, .ARR_CMD_AREA, .ARR_CMD_ADDR,
  .ARR_WR_STB, .ARR_DONE, .BUSY);

// File: sim/fsq_array_model.sv
// flash array stand-in: address pattern data and delayed completion
`timescale 1ns/10ps
module fsq_array_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] dly,
  input wire logic rd_area,
  input wire logic [18:0] rd_addr,
  output logic [31:0] rd_data,
  input wire logic cmd_stb,
  input wire logic [1:0] cmd_area,
  input wire logic wr_stb,
  output logic [1:0] done
);
  logic [4:0] cnt_r [2];
  wire bank = cmd_area == 2'h1;
  // data tied to area and offset exposes address mix-ups
  assign rd_data = {12'ha5c, rd_area, rd_addr};
  for (genvar b = 0; b < 2; b++)
  begin : g_bank
    assign done[b] = cnt_r[b] == 5'h01;
    // the count holds while words still arrive, so completion never beats the data
    always_ff @(posedge clk)
      if (rst)
        cnt_r[b] <= 5'h00;
      else if (cmd_stb && bank == b)
        cnt_r[b] <= dly;
      else if (cnt_r[b] != 5'h00 && !wr_stb)
        cnt_r[b] <= cnt_r[b] - 5'h01;
  end
endmodule

// File: sim/flash_read_and_program_control_test.sv
// self-checking bench for the flash sequencer
`timescale 1ns/10ps
module flash_read_and_program_control_test;
  logic SYS_CLK = 1'b0, SRST = 1'b1, RD_REQ = 1'b0, RD_AREA = 1'b0, RD_CPU_HIT = 1'b0, RD_FLASH_HIT = 1'b0;
  logic CMD_WR = 1'b0, SER_WR = 1'b0, PE_ENABLE = 1'b1, OPT_EXPAND = 1'b0;
  logic [18:0] RD_ADDR = 19'h00000;
  logic [7:0] FLASH_READ_WAIT_SELECT = 8'h00;
  logic [31:0] CMD_ADDR = fsq_pkg::CMD_WINDOW, CMD_WDATA = 32'h0, SER_WDATA = 32'h0;
  logic RD_READY, RD_VALID, CMD_READY, SER_READY, ARR_RD_AREA, ARR_CMD_STB, ARR_WR_STB, CMD_ERR;
  logic [31:0] RD_DATA, ARR_RD_DATA, ARR_WR_DATA;
  logic [18:0] ARR_RD_ADDR, ARR_CMD_ADDR;
  logic [1:0] ARR_CMD_OP, ARR_CMD_AREA, ARR_DONE, BUSY;
  logic [4:0] dly = 5'h04;
  logic [31:0] q [$];
  logic [1:0] bad_area [4] = '{2'h1, 2'h3, 2'h1, 2'h0};
  logic [19:0] bad_off [4] = '{20'h00000, 20'h00000, 20'h10000, 20'h80000};
  int error_cnt = 0, total_checks = 0, cyc = 0, stb_cnt = 0;
  fsq_flash_ctrl i_fsq_flash_ctrl (.*);
  fsq_array_model i_fsq_array_model (.clk(SYS_CLK), .rst(SRST), .dly(dly), .rd_area(ARR_RD_AREA),
    .rd_addr(ARR_RD_ADDR), .rd_data(ARR_RD_DATA), .cmd_stb(ARR_CMD_STB), .cmd_area(ARR_CMD_AREA),
    .wr_stb(ARR_WR_STB), .done(ARR_DONE));
  always #12.5 SYS_CLK = ~SYS_CLK;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge SYS_CLK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      complete_run();
    end
  end
  // stream words are compared mid-cycle, away from the launching edge
  always @(negedge SYS_CLK)
  begin
    if (ARR_CMD_STB === 1'b1)
      stb_cnt++;
    if (ARR_WR_STB === 1'b1)
      chk(ARR_WR_DATA, q.size() > 0 ? q.pop_front() : ~ARR_WR_DATA);
  end
  function automatic logic [31:0] lat(input logic c, input logic f, input logic [7:0] w);
    return c ? 32'h1 : (f || w == fsq_pkg::WAIT_SEL_FAST) ? 32'h3 : 32'h4;
  endfunction
  function automatic logic [31:0] pat(input logic a, input logic [18:0] ad);
    return {12'ha5c, a, ad};
  endfunction
  task automatic tick();
    @(posedge SYS_CLK);
    #1;
  endtask
  task automatic rd(input logic a, input logic [18:0] ad, input logic c, input logic f, input logic [31:0] exp);
    logic [31:0] n;
    RD_REQ = 1'b1;
    RD_AREA = a;
    RD_ADDR = ad;
    RD_CPU_HIT = c;
    RD_FLASH_HIT = f;
    while (RD_READY !== 1'b1)
      tick();
    tick();
    RD_REQ = 1'b0;
    n = 0;
    while (RD_VALID !== 1'b1 && n < 9)
    begin
      tick();
      n++;
    end
    chk(n, lat(c, f, FLASH_READ_WAIT_SELECT));
    chk(RD_DATA, exp);
  endtask
  task automatic wr(input logic s, input logic [31:0] w);
    CMD_WR = !s;
    SER_WR = s;
    CMD_WDATA = w;
    SER_WDATA = w;
    while ((s ? SER_READY : CMD_READY) !== 1'b1)
      tick();
    tick();
  endtask
  task automatic cmd(input logic s, input logic [7:0] op, input logic [1:0] ar, input logic [19:0] off, input int n);
    logic [31:0] w;
    wr(s, {24'h0, op});
    wr(s, {6'h00, ar, 4'h0, off});
    repeat (n)
    begin
      w = $urandom;
      q.push_back(w);
      wr(s, w);
    end
    CMD_WR = 1'b0;
    SER_WR = 1'b0;
    // let an edge pass so a following command never re-raises the strobe in the same step
    tick();
  endtask
  initial
  begin
    logic a;
    logic [18:0] ad;
    int n0;
    int m;
    void'($urandom(32'h82b2));
    repeat (2) @(posedge SYS_CLK);
    #1;
    SRST = 1'b0;
    for (int i = 0; i < 32; i++)
    begin
      a = 1'($urandom);
      ad = 19'($urandom);
      FLASH_READ_WAIT_SELECT = i[3:2] == 2'h0 ? 8'h00 : i[3:2] == 2'h1 ? 8'h01 : 8'($urandom_range(255, 2));
      rd(a, ad, i[0], i[1], pat(a, ad));
    end
    dly = 5'h1e;
    RD_AREA = 1'b1;
    cmd(1'b0, 8'h02, 2'h1, 20'h02000, 0);
    while (BUSY[1] !== 1'b1)
      tick();
    rd(1'b0, 19'h00040, 1'b0, 1'b0, pat(1'b0, 19'h00040));
    chk(BUSY[1], 1'b1);
    while (BUSY !== 2'h0)
      tick();
    rd(1'b1, 19'h03ffc, 1'b0, 1'b0, 32'hffff_ffff);
    rd(1'b1, 19'h04000, 1'b0, 1'b0, pat(1'b1, 19'h04000));
    dly = 5'h1c;
    cmd(1'b1, 8'h01, 2'h0, 20'h7ff80, 32);
    while (BUSY[0] !== 1'b1)
      tick();
    rd(1'b1, 19'h01000, 1'b0, 1'b1, pat(1'b1, 19'h01000));
    chk(BUSY[0], 1'b1);
    n0 = stb_cnt;
    dly = 5'h02;
    cmd(1'b0, 8'h03, 2'h2, 20'h00004, 4);
    dly = 5'h08;
    cmd(1'b0, 8'h02, 2'h0, 20'h08000, 0);
    while (stb_cnt < n0 + 2)
      tick();
    while (BUSY !== 2'h0)
      tick();
    rd(1'b0, 19'h0fffc, 1'b0, 1'b0, 32'hffff_ffff);
    rd(1'b0, 19'h10000, 1'b0, 1'b0, pat(1'b0, 19'h10000));
    n0 = stb_cnt;
    CMD_ADDR = fsq_pkg::CMD_WINDOW + 32'h0000_0004;
    cmd(1'b0, 8'h02, 2'h0, 20'h00000, 0);
    CMD_ADDR = fsq_pkg::CMD_WINDOW;
    repeat (4) tick();
    chk(32'(stb_cnt - n0), 32'h0);
    for (int k = 0; k < 6; k++)
    begin
      n0 = stb_cnt;
      PE_ENABLE = (k != 0);
      if (k < 4)
        cmd(1'b0, 8'h02, bad_area[k], bad_off[k], 0);
      else if (k == 4)
      begin
        // option offset past the base area without expansion
        cmd(1'b0, 8'h03, 2'h2, 20'h00010, 4);
        q.delete();
      end
      else
      begin
        wr(1'b0, 32'h0000_0007);
        CMD_WR = 1'b0;
      end
      m = 0;
      while (CMD_ERR !== 1'b1 && m < 20)
      begin
        tick();
        m++;
      end
      chk(CMD_ERR, 1'b1);
      chk(32'(stb_cnt - n0), 32'h0);
    end
    // second reset with the expansion area chosen: the same offset must now launch
    OPT_EXPAND = 1'b1;
    SRST = 1'b1;
    repeat (2) tick();
    SRST = 1'b0;
    n0 = stb_cnt;
    cmd(1'b0, 8'h03, 2'h2, 20'h00010, 4);
    while (BUSY !== 2'h0 || stb_cnt == n0)
      tick();
    chk(32'(stb_cnt - n0), 32'h1);
    chk(32'(q.size()), 32'h0);
    complete_run();
  end
endmodule
